// [design/uit_core.sv]
// Serial transmitter/receiver core with interrupt timing and modem lines.
`timescale 1ns/10ps
`default_nettype none
`include "uit_params.svh"

// Function
// (R1) Receive interrupt one baud cycle after stop.
// (R2) Receive buffer read clears receive interrupt.
// (R3) Holding register write clears empty interrupt.
// (R4) Start bit 8 to 24 cycles after load.
// (R5) Empty interrupt 16 to 32 after first write.
// (R6) Empty interrupt 8 to 24 after stop.
// (R7) Identification read reporting empty clears it.
// (R8) Modem input change sets modem interrupt.
// (R9) Modem status read clears modem interrupt.
// (R10) Control write updates modem output pins.
// (R11) Sixteen baud clock cycles per bit.
// (R12) Baud clock is input divided by divisor.
module uit_core #(
  parameter int DIV_W      = `UIT_DIV_W,
  parameter int FIFO_DEPTH = `UIT_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Baud generator.
  input  wire logic [DIV_W-1:0]            divisor,
  output logic                             baud_clock_out,
  // Host strobes and data.
  input  wire logic [`UIT_DATA_BITS-1:0]   wr_data,
  input  wire logic                        write_strobe_thr,
  output logic                             thr_ready,
  input  wire logic                        write_strobe_mcr,
  input  wire logic                        read_strobe_rbr,
  input  wire logic                        read_strobe_iir,
  input  wire logic                        read_strobe_msr,
  // Host status.
  output logic [`UIT_DATA_BITS-1:0]        receive_buffer,
  output logic [1:0]                       interrupt_identification,
  output logic [7:0]                       modem_status_reg,
  output logic                             transmit_holding_empty,
  output logic                             interrupt_request,
  // Serial line and modem pins.
  input  wire logic                        sin,
  output logic                             sout,
  input  wire logic [`UIT_MODEM_IN_W-1:0]  modem_in,
  output logic [`UIT_MODEM_OUT_W-1:0]      modem_out
);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  logic [DIV_W-1:0]           bcnt_q;
  logic                       tick;
  logic                       bclk_q;
  uit_pkg::uit_tx_state_e     tx_q;
  uit_pkg::uit_rx_state_e     rx_q;
  logic [`UIT_SUB_W-1:0]      phase_q;
  logic [`UIT_SUB_W-1:0]      tsub_q;
  logic [`UIT_SUB_W-1:0]      rsub_q;
  logic [2:0]                 tbit_q;
  logic [2:0]                 rbit_q;
  logic [`UIT_WAIT_W-1:0]     wait_q;
  logic [`UIT_DATA_BITS-1:0]  tsh_q;
  logic [`UIT_DATA_BITS-1:0]  rsh_q;
  logic [`UIT_DATA_BITS-1:0]  rbuf_q;
  logic                       sout_q;
  logic                       rx_done_q;
  logic                       rx_pend_q;
  logic                       transmit_holding_empty_pend_q;
  logic                       ms_pend_q;
  logic                       irq_q;
  uit_pkg::uit_iir_e          iir_q;
  logic [`UIT_MODEM_IN_W-1:0] min_q;
  logic [`UIT_MODEM_IN_W-1:0] mdelta_q;
  logic [`UIT_MODEM_OUT_W-1:0] mout_q;
  logic                       fifo_valid;
  logic [`UIT_DATA_BITS-1:0]  fifo_data;
  logic [CNT_W-1:0]           fifo_count;
  logic                       tx_start;
  logic                       tx_pop;
  logic                       thr_load;
  logic                       rx_set;
  logic                       transmit_holding_empty_set;
  logic                       ms_set;

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // A divisor of zero is illegal and behaves as one, so the tick never stops.
  assign tick = ((DIV_W + 1)'(bcnt_q) + (DIV_W + 1)'(1)) >= (DIV_W + 1)'(divisor); // R12

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bcnt_q  <= '0;
      bclk_q  <= 1'b0;
      phase_q <= '0;
    end
    else
    begin
      bcnt_q <= tick ? '0 : bcnt_q + DIV_W'(1); // R12
      bclk_q <= tick;
      if (tick)
      begin
        phase_q <= phase_q + `UIT_SUB_W'(1); // R11
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit holding FIFO and transmitter
  // ----------------------------------------------------------------
  assign thr_load = write_strobe_thr && thr_ready;
  assign tx_start = (tx_q == uit_pkg::TX_IDLE) && tick && fifo_valid
                    && (wait_q + `UIT_WAIT_W'(1) >= `UIT_TX_WAIT_MIN) && (phase_q == `UIT_SUB_LAST);
  assign tx_pop   = (tx_q == uit_pkg::TX_START) && tick && (tsub_q == `UIT_TX_POP);

  uit_fifo #(
    .WIDTH (`UIT_DATA_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_thr_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (write_strobe_thr),
    .in_ready  (thr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (tx_pop),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // The start bit waits for a bit boundary at least eight ticks after load.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tx_q   <= uit_pkg::TX_IDLE;
      tsub_q <= '0;
      tbit_q <= '0;
      wait_q <= '0;
      tsh_q  <= '0;
      sout_q <= 1'b1;
    end
    else
    begin
      case (tx_q)
        uit_pkg::TX_IDLE:
        begin
          sout_q <= 1'b1;
          if (!fifo_valid)
          begin
            wait_q <= '0;
          end
          else if (tx_start)
          begin
            tx_q   <= uit_pkg::TX_START; // R4
            tsub_q <= '0;
            sout_q <= 1'b0;
          end
          else if (tick && wait_q < `UIT_TX_WAIT_MIN)
          begin
            wait_q <= wait_q + `UIT_WAIT_W'(1);
          end
        end
        uit_pkg::TX_START, uit_pkg::TX_DATA, uit_pkg::TX_STOP:
        begin
          if (tx_pop)
          begin
            tsh_q <= fifo_data;
          end
          if (tick)
          begin
            tsub_q <= tsub_q + `UIT_SUB_W'(1); // R11
            if (tsub_q == `UIT_SUB_LAST)
            begin
              if (tx_q == uit_pkg::TX_START)
              begin
                tx_q   <= uit_pkg::TX_DATA;
                tbit_q <= '0;
                sout_q <= tsh_q[0];
              end
              else if (tx_q == uit_pkg::TX_DATA && tbit_q != 3'h7)
              begin
                tbit_q <= tbit_q + 3'h1;
                sout_q <= tsh_q[tbit_q + 3'h1];
              end
              else if (tx_q == uit_pkg::TX_DATA)
              begin
                tx_q   <= uit_pkg::TX_STOP;
                sout_q <= 1'b1;
              end
              else if (fifo_valid)
              begin
                tx_q   <= uit_pkg::TX_START; // R6
                sout_q <= 1'b0;
              end
              else
              begin
                tx_q   <= uit_pkg::TX_IDLE;
                wait_q <= '0;
              end
            end
          end
        end
        default:
        begin
          tx_q <= uit_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_q      <= uit_pkg::RX_IDLE;
      rsub_q    <= '0;
      rbit_q    <= '0;
      rsh_q     <= '0;
      rbuf_q    <= '0;
      rx_done_q <= 1'b0;
    end
    else if (tick)
    begin
      rsub_q    <= rsub_q + `UIT_SUB_W'(1); // R11
      rx_done_q <= 1'b0;
      case (rx_q)
        uit_pkg::RX_IDLE:
        begin
          rsub_q <= '0;
          if (!sin)
          begin
            rx_q <= uit_pkg::RX_START;
          end
        end
        uit_pkg::RX_START:
        begin
          if (rsub_q == `UIT_RX_MID)
          begin
            rx_q   <= sin ? uit_pkg::RX_IDLE : uit_pkg::RX_DATA;
            rsub_q <= '0;
            rbit_q <= '0;
          end
        end
        uit_pkg::RX_DATA:
        begin
          if (rsub_q == `UIT_SUB_LAST)
          begin
            rsh_q  <= {sin, rsh_q[`UIT_DATA_BITS-1:1]};
            rbit_q <= rbit_q + 3'h1;
            if (rbit_q == 3'h7)
            begin
              rx_q <= uit_pkg::RX_STOP;
            end
          end
        end
        uit_pkg::RX_STOP:
        begin
          if (rsub_q == `UIT_SUB_LAST)
          begin
            rbuf_q    <= rsh_q;
            rx_done_q <= 1'b1;
            rx_q      <= uit_pkg::RX_IDLE;
          end
        end
        default:
        begin
          rx_q <= uit_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // A set in the same cycle as a clear always wins, so no event is lost.
  assign rx_set   = rx_done_q && tick; // R1
  // A word pushed in the same cycle keeps the holding side busy, so no empty event then.
  assign transmit_holding_empty_set = tx_pop && (fifo_count == CNT_W'(1)) && !thr_load; // R5 R6
  assign ms_set   = (modem_in != min_q); // R8

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_pend_q   <= 1'b0;
      transmit_holding_empty_pend_q <= 1'b0;
      ms_pend_q   <= 1'b0;
    end
    else
    begin
      rx_pend_q   <= rx_set || (rx_pend_q && !read_strobe_rbr); // R1 R2
      transmit_holding_empty_pend_q <= transmit_holding_empty_set || (transmit_holding_empty_pend_q && !thr_load // R3
                     && !(read_strobe_iir && iir_q == uit_pkg::IIR_TRANSMIT_HOLDING_EMPTY)); // R7
      ms_pend_q   <= ms_set || (ms_pend_q && !read_strobe_msr); // R8 R9
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      iir_q <= uit_pkg::IIR_NONE;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= rx_pend_q || transmit_holding_empty_pend_q || ms_pend_q;
      if (rx_pend_q)
      begin
        iir_q <= uit_pkg::IIR_RX;
      end
      else if (transmit_holding_empty_pend_q)
      begin
        iir_q <= uit_pkg::IIR_TRANSMIT_HOLDING_EMPTY;
      end
      else if (ms_pend_q)
      begin
        iir_q <= uit_pkg::IIR_MODEM;
      end
      else
      begin
        iir_q <= uit_pkg::IIR_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Modem lines
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      min_q    <= '0;
      mdelta_q <= '0;
      mout_q   <= `UIT_MODEM_OUT_RST;
    end
    else
    begin
      min_q    <= modem_in;
      mdelta_q <= (modem_in ^ min_q) | (read_strobe_msr ? '0 : mdelta_q); // R8 R9
      if (write_strobe_mcr)
      begin
        mout_q <= wr_data[`UIT_MODEM_OUT_W-1:0]; // R10
      end
    end
  end

  assign baud_clock_out           = bclk_q;
  assign sout                     = sout_q;
  assign receive_buffer           = rbuf_q;
  assign interrupt_identification = iir_q;
  assign modem_status_reg         = {min_q, mdelta_q};
  assign transmit_holding_empty   = !fifo_valid;
  assign interrupt_request        = irq_q;
  assign modem_out                = mout_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] since_load_q;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || (tx_q == uit_pkg::TX_IDLE && !fifo_valid))
    begin
      since_load_q <= '0;
    end
    else if (tick && tx_q != uit_pkg::TX_DATA && since_load_q != 8'hff)
    begin
      since_load_q <= since_load_q + 8'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_rx_int_set:    assert property (rx_done_q && tick |=> rx_pend_q) // R1
    else $error("receive interrupt not raised one tick after stop");
  a_rx_int_clear:  assert property (read_strobe_rbr && !rx_set |=> !rx_pend_q) // R2
    else $error("receive buffer read did not clear interrupt");
  a_thr_clear:     assert property (thr_load && !transmit_holding_empty_set |=> !transmit_holding_empty_pend_q) // R3
    else $error("holding write did not clear empty interrupt");
  a_start_window:  assert property (tx_start && since_load_q < 8'd50 |-> ##1
                     (since_load_q >= 8'd8 && since_load_q <= 8'd24 && !sout)) // R4
    else $error("start bit outside window after load");
  a_first_transmit_holding_empty:    assert property (transmit_holding_empty_set && $past(since_load_q) < 8'd40 |->
                     (since_load_q >= 8'd15 && since_load_q <= 8'd32)) // R5
    else $error("empty interrupt outside window after first write");
  a_stop_transmit_holding_empty:     assert property (tx_pop |-> tx_q == uit_pkg::TX_START && tsub_q == `UIT_TX_POP) // R6
    else $error("holding word taken outside start bit");
  a_iir_clear:     assert property (read_strobe_iir && iir_q == uit_pkg::IIR_TRANSMIT_HOLDING_EMPTY && !transmit_holding_empty_set
                     |=> !transmit_holding_empty_pend_q) // R7
    else $error("identification read did not clear empty interrupt");
  a_modem_set:     assert property (modem_in != min_q |=> ms_pend_q ##1 irq_q) // R8
    else $error("modem change did not raise interrupt");
  a_msr_clear:     assert property (read_strobe_msr && !ms_set |=> !ms_pend_q) // R9
    else $error("modem status read did not clear interrupt");
  a_mcr_out:       assert property (write_strobe_mcr |=> modem_out == $past(wr_data[1:0])) // R10
    else $error("modem outputs not updated after control write");

  c_rx_char:   cover property (rx_done_q ##1 rx_pend_q [*2] ##1 read_strobe_rbr);
  c_tx_back:   cover property (tx_q == uit_pkg::TX_STOP && fifo_valid ##1 tx_q == uit_pkg::TX_START);
  c_fifo_full: cover property (!thr_ready && write_strobe_thr);
  c_iir_transmit_holding_empty:  cover property (read_strobe_iir && iir_q == uit_pkg::IIR_TRANSMIT_HOLDING_EMPTY);
endmodule : uit_core
`default_nettype wire

// [pkg/uit_params.svh]
// Constants for the serial interrupt timing block.
`ifndef UIT_PARAMS_SVH
`define UIT_PARAMS_SVH

`define UIT_DIV_W         16
`define UIT_DATA_BITS     8
`define UIT_FIFO_DEPTH    8
`define UIT_MODEM_IN_W    4
`define UIT_MODEM_OUT_W   2
`define UIT_MODEM_OUT_RST 2'h0
// Baud clock cycles per serial bit, and the last tick index of a bit.
`define UIT_TICKS_PER_BIT 16
`define UIT_SUB_W         4
`define UIT_SUB_LAST      4'hf
// Tick index within the start bit where the receiver samples mid bit.
`define UIT_RX_MID        4'h7
// Tick index within the start bit where the holding word is taken.
`define UIT_TX_POP        4'h7
// Least baud cycles from first load to start bit, and wait counter width.
`define UIT_TX_WAIT_MIN   5'h08
`define UIT_WAIT_W        5
// Baud cycles from stop sample to receive interrupt.
`define UIT_RX_INT_DELAY  1
// Window limits in baud cycles for the checks.
`define UIT_START_MAX     24
`define UIT_TRANSMIT_HOLDING_EMPTY_MIN      16
`define UIT_TRANSMIT_HOLDING_EMPTY_MAX      32

`endif

// [pkg/uit_pkg.sv]
// Types for the serial interrupt timing block.
package uit_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uit_tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uit_rx_state_e;
  typedef enum logic [1:0] {IIR_NONE, IIR_MODEM, IIR_TRANSMIT_HOLDING_EMPTY, IIR_RX} uit_iir_e;
endpackage : uit_pkg

// [design/uit_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module uit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = $clog2(DEPTH + 1),
  parameter int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CNT_W-1:0]      count
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [CNT_W-1:0] cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != CNT_W'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_q + PTR_W'(1);
      end
      if (pop)
      begin
        rd_q <= (rd_q == PTR_W'(DEPTH - 1)) ? '0 : rd_q + PTR_W'(1);
      end
      cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule : uit_fifo
`default_nettype wire

// [tb/uit_serial_peer.sv]
// Serial line partner: sends frames on sin and decodes frames seen on sout.
`timescale 1ns/10ps
`default_nettype none
`include "uit_params.svh"
module uit_serial_peer (
  // Clock and baud tick.
  input  wire logic ref_clk,
  input  wire logic tick,
  // Serial lines.
  input  wire logic sout,
  output logic      sin
);
  int         ticks = 0;
  int         frame_err = 0;
  logic [7:0] rx_q[$];
  int         start_q[$];
  logic [7:0] d;

  always @(posedge ref_clk)
  begin
    if (tick === 1'b1)
      ticks <= ticks + 1;
  end

  task automatic wait_ticks(input int n);
    repeat (n) @(posedge ref_clk iff tick === 1'b1);
  endtask : wait_ticks

  // One start bit, eight data bits LSB first, one stop bit; the line idles high.
  task automatic send(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge ref_clk iff tick === 1'b1);
      sin <= f[i];
      wait_ticks(`UIT_TICKS_PER_BIT - 1);
    end
  endtask : send

  // Bits are sampled mid bit, so a bit narrower than sixteen ticks shows as a bad frame.
  initial
  begin
    sin = 1'b1;
    forever
    begin
      @(negedge ref_clk iff sout === 1'b0);
      // The tick that launched the start bit is only counted on the next edge, so add it here.
      start_q.push_back(ticks + 1);
      wait_ticks(8);
      for (int i = 0; i < 8; i++)
      begin
        wait_ticks(16);
        d[i] = sout;
      end
      wait_ticks(16);
      if (sout !== 1'b1)
        frame_err++;
      rx_q.push_back(d);
    end
  end
endmodule : uit_serial_peer
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the serial interrupt timing core.
`timescale 1ns/10ps
`default_nettype none
`include "uit_params.svh"
module testbench;
  localparam int TRANSMIT_HOLDING = 0, MCR = 1, RECEIVE_BUFFER = 2, INTERRUPT_IDENTIFICATION = 3, MODEM_STATUS_REG = 4;
  logic        ref_clk;
  logic        rst_n;
  logic [15:0] divisor;
  logic        baud_clock_out;
  logic [7:0]  wr_data;
  logic [4:0]  stb;
  logic        thr_ready;
  logic [7:0]  receive_buffer;
  logic [1:0]  interrupt_identification;
  logic [7:0]  modem_status_reg;
  logic        transmit_holding_empty;
  logic        interrupt_request;
  logic        sin;
  logic        sout;
  logic [3:0]  modem_in;
  logic [1:0]  modem_out;
  int          err_total = 0;
  int          n_checks = 0;
  int          t0;
  int          n;

  uit_core dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .divisor(divisor), .baud_clock_out(baud_clock_out),
    .wr_data(wr_data), .write_strobe_thr(stb[TRANSMIT_HOLDING]), .thr_ready(thr_ready),
    .write_strobe_mcr(stb[MCR]), .read_strobe_rbr(stb[RECEIVE_BUFFER]), .read_strobe_iir(stb[INTERRUPT_IDENTIFICATION]),
    .read_strobe_msr(stb[MODEM_STATUS_REG]), .receive_buffer(receive_buffer),
    .interrupt_identification(interrupt_identification), .modem_status_reg(modem_status_reg),
    .transmit_holding_empty(transmit_holding_empty), .interrupt_request(interrupt_request),
    .sin(sin), .sout(sout), .modem_in(modem_in), .modem_out(modem_out)
  );

  uit_serial_peer peer (.ref_clk(ref_clk), .tick(baud_clock_out), .sout(sout), .sin(sin));

  // ----------------------------------------------------------------
  // Host access and checking tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      err_total++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  // One-cycle host strobe; the design takes it at the edge on which the task returns.
  task automatic strobe(input int sel, input logic [7:0] v);
    @(posedge ref_clk);
    wr_data <= v;
    stb <= 5'h01 << sel;
    @(posedge ref_clk);
    stb <= 5'h00;
  endtask : strobe

  task automatic wait_irq(input logic lvl, input int lim, input string what);
    n = 0;
    while (interrupt_request !== lvl && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(what, lvl, interrupt_request);
  endtask : wait_irq

  task automatic wait_rx(input int cnt);
    n = 0;
    while (peer.rx_q.size() < cnt && n < 4000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("chars received", cnt, peer.rx_q.size());
  endtask : wait_rx

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // The whole sequence needs about 4000 cycles at divisor 2.
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end

  initial
  begin
    rst_n = 1'b0;
    divisor = 16'h0003;
    wr_data = 8'h00;
    stb = 5'h00;
    modem_in = 4'h0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int dv = 3; dv >= 2; dv--)
    begin
      divisor <= dv[15:0];
      repeat (2) @(negedge ref_clk iff baud_clock_out === 1'b1);
      n = 0;
      do
      begin
        @(negedge ref_clk);
        n++;
      end while (baud_clock_out !== 1'b1 && n < 10);
      chk_rng("baud period", dv, dv, n);
    end
    strobe(TRANSMIT_HOLDING, 8'ha5);
    t0 = peer.ticks;
    @(negedge ref_clk);
    chk("transmit_holding_empty flag on load", 1'b0, transmit_holding_empty);
    wait_irq(1'b1, 100, "transmit_holding_empty raise");
    chk_rng("first load to start", 8, 24, peer.start_q[0] - t0);
    chk_rng("first load to transmit_holding_empty", 16, 32, peer.ticks - t0);
    chk("transmit_holding_empty source", 2'h2, interrupt_identification);
    strobe(INTERRUPT_IDENTIFICATION, 8'h00);
    wait_irq(1'b0, 3, "ident read clears transmit_holding_empty");
    wait_rx(1);
    chk("tx char", 8'ha5, peer.rx_q[0]);
    peer.wait_ticks(40);
    for (int i = 0; i < 9; i++)
    begin
      @(negedge ref_clk);
      if (i == 8)
        chk("holding full", 1'b0, thr_ready);
      strobe(TRANSMIT_HOLDING, 8'h10 + i[7:0]);
    end
    wait_irq(1'b1, 3000, "transmit_holding_empty after drain");
    n = peer.start_q.size();
    chk_rng("stop to transmit_holding_empty", 8, 24, peer.ticks - (peer.start_q[n-2] + 144));
    strobe(TRANSMIT_HOLDING, 8'h5a);
    wait_irq(1'b0, 3, "load clears transmit_holding_empty");
    wait_rx(10);
    for (int i = 0; i < 8; i++)
      chk("queued char", 8'h10 + i[7:0], peer.rx_q[1+i]);
    chk("char after refused one", 8'h5a, peer.rx_q[9]);
    chk("frame errors", 0, peer.frame_err);
    strobe(INTERRUPT_IDENTIFICATION, 8'h00);
    wait_irq(1'b0, 3, "ident read clears transmit_holding_empty");
    fork
      peer.send(8'h3c);
    join_none
    n = 0;
    while (receive_buffer !== 8'h3c && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    // The stop sample tick itself reaches the peer's counter one cycle later.
    t0 = peer.ticks + 1;
    wait_irq(1'b1, 20, "rx raise");
    chk_rng("stop to rx interrupt", 1, 1, peer.ticks - t0);
    chk("rx source", 2'h3, interrupt_identification);
    chk("rx data", 8'h3c, receive_buffer);
    strobe(RECEIVE_BUFFER, 8'h00);
    wait_irq(1'b0, 3, "buffer read clears rx");
    for (int b = 0; b < 4; b++)
    begin
      @(posedge ref_clk);
      modem_in <= modem_in ^ (4'h1 << b);
      wait_irq(1'b1, 5, "modem raise");
      chk("modem source", 2'h1, interrupt_identification);
      chk("modem lines", modem_in, modem_status_reg[7:4]);
      chk("modem delta", 4'h1 << b, modem_status_reg[3:0]);
      strobe(MODEM_STATUS_REG, 8'h00);
      wait_irq(1'b0, 3, "status read clears modem");
      chk("modem delta cleared", 4'h0, modem_status_reg[3:0]);
      strobe(MCR, 8'hfc | b[7:0]);
      @(negedge ref_clk);
      chk("modem outputs", b[1:0], modem_out);
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
